//--- logic/timer_params.svh
// register map, field positions, reset values and prescaler figures of the 8-bit timer
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

// byte addresses of the registers
`define ADDR_CONTROL 4'h0
`define ADDR_COMPARE 4'h4
`define ADDR_STATUS 4'h8
`define ADDR_CONFIG 4'hc

// control register fields
`define CTRL_CLK_LSB 0
`define CTRL_CLK_MSB 2
`define CTRL_MODE_LSB 3
`define CTRL_MODE_MSB 4
`define CTRL_RUN_BIT 5

// status register fields
`define STAT_CNT_LSB 0
`define STAT_CNT_MSB 7
`define STAT_DIV_BIT 8
`define STAT_PWM_BIT 9

// config register fields
`define CFG_DIVSEL_BIT 0

// reset values
`define RST_COMPARE 8'hff
`define RST_CLK_SEL 3'h0
`define RST_COUNT 8'h00
`define RST_PRESC 12'h000

// prescaler: source clock is high_freq_clock divided by 2**shift
`define PRESC_W 12
`define SHIFT_CODE0 4'hb
`define SHIFT_CODE1 4'h7
`define SHIFT_CODE2 4'h5
`define SHIFT_CODE3 4'h3
`define SHIFT_CODE4 4'h2
`define SHIFT_CODE5 4'h1
`define SHIFT_CODE6 4'h0
`define CLK_CODE_EXT 3'h7

// least high or low phase of the count input, in high_freq_clock periods
`define EVT_MIN_PHASE_CYCLES 8

// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- logic/timer_pkg.sv
// types shared by the 8-bit timer
package timer_pkg;
    typedef enum logic [1:0] {
        mode_timer,
        mode_event,
        mode_pdo,
        mode_pwm
    } mode_e;
    typedef logic [7:0] count_t;
endpackage

//--- logic/eight_bit_multimode_timer.sv
// 8-bit multimode timer/counter with an AXI4-Lite register port
//
// Operation
// - interval mode counts prescaled clock; on compare match raise irq, clear, resume.
// - event mode counts count input rising edges, resumes after match clear.
// - event mode checks match on count input falling edge, irq there.
// - divider mode toggles active-low output on each match, irq, clear, continue.
// - divider output held high while stopped.
// - pwm mode drives output low at duty match, high with irq on overflow.
// - pwm output held high while stopped.
// - pwm duty writes take effect only when the current period completes.
// - starting the timer loads the previously written duty value at once.
// - entering stop mode clears the run bit automatically.
// - control register bits 6 and 7 read as zero.
// - clock codes 000 to 011 divide by 2048, 128, 32, 8; divide select doubles.
`timescale 1ns/1ps
`include "timer_params.svh"

module eight_bit_multimode_timer (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [31:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic count_input_pin,
    input wire logic stop_entry,
    output logic timer_match_irq,
    output logic divider_output_n,
    output logic pulse_width_output_n
);

    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic wr_take;
    logic rd_take;

    logic run_q;
    timer_pkg::mode_e mode_q;
    logic [2:0] clk_sel_q;
    logic div_sel_q;
    timer_pkg::count_t compare_q;
    timer_pkg::count_t duty_q;
    timer_pkg::count_t cnt_q;
    timer_pkg::count_t cnt_inc;
    logic [`PRESC_W-1:0] presc_q;
    logic [`PRESC_W-1:0] presc_mask;
    logic [3:0] shift;
    logic tick;
    logic irq_q;
    logic div_out_q;
    logic pwm_out_q;

    logic pin_meta_q;
    logic pin_sync_q;
    logic pin_prev_q;
    logic pin_rise;
    logic pin_fall;

    // ---------------- register port ----------------
    // write address and data are taken together; neither is taken alone
    assign wr_take = awvalid && wvalid && !bvalid_q;
    assign awready = wr_take;
    assign wready = wr_take;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign rd_take = arvalid && !rvalid_q;
    assign arready = rd_take;
    assign rvalid = rvalid_q;
    assign rresp = rresp_q;
    assign rdata = rdata_q;

    function automatic logic addr_ok(input logic [31:0] a);
        addr_ok = (a[31:4] == 28'h0000000) && (a[1:0] == 2'h0);
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= `RESP_OKAY;
        end else if (wr_take) begin
            bvalid_q <= 1'b1;
            bresp_q <= addr_ok(awaddr) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // software settings; all fields live in byte lane 0
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_q <= 1'b0;
            mode_q <= timer_pkg::mode_timer;
            clk_sel_q <= `RST_CLK_SEL;
            div_sel_q <= 1'b0;
            compare_q <= `RST_COMPARE;
        end else begin
            if (wr_take && wstrb[0] && addr_ok(awaddr)) begin
                case (awaddr[3:0])
                    `ADDR_CONTROL: begin
                        run_q <= wdata[`CTRL_RUN_BIT];
                        mode_q <= timer_pkg::mode_e'(wdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
                        clk_sel_q <= wdata[`CTRL_CLK_MSB:`CTRL_CLK_LSB];
                    end
                    `ADDR_COMPARE: begin
                        compare_q <= wdata[7:0];
                    end
                    `ADDR_CONFIG: begin
                        div_sel_q <= wdata[`CFG_DIVSEL_BIT];
                    end
                    default: begin
                    end
                endcase
            end
            // the hardware stop wins over a software start in the same cycle
            if (stop_entry) begin
                run_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rresp_q <= `RESP_OKAY;
            rdata_q <= 32'h00000000;
        end else if (rd_take) begin
            rvalid_q <= 1'b1;
            rresp_q <= addr_ok(araddr) ? `RESP_OKAY : `RESP_SLVERR;
            rdata_q <= 32'h00000000;
            if (addr_ok(araddr)) begin
                case (araddr[3:0])
                    `ADDR_CONTROL: begin
                        // bits 6 and 7 carry no meaning and read as zero
                        rdata_q[`CTRL_RUN_BIT] <= run_q;
                        rdata_q[`CTRL_MODE_MSB:`CTRL_MODE_LSB] <= mode_q;
                        rdata_q[`CTRL_CLK_MSB:`CTRL_CLK_LSB] <= clk_sel_q;
                    end
                    `ADDR_COMPARE: begin
                        rdata_q[7:0] <= compare_q;
                    end
                    `ADDR_STATUS: begin
                        rdata_q[`STAT_CNT_MSB:`STAT_CNT_LSB] <= cnt_q;
                        rdata_q[`STAT_DIV_BIT] <= div_out_q;
                        rdata_q[`STAT_PWM_BIT] <= pwm_out_q;
                    end
                    `ADDR_CONFIG: begin
                        rdata_q[`CFG_DIVSEL_BIT] <= div_sel_q;
                    end
                    default: begin
                    end
                endcase
            end
        end else if (rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ---------------- prescaler ----------------
    always_comb begin
        case (clk_sel_q)
            3'h0: shift = `SHIFT_CODE0;
            3'h1: shift = `SHIFT_CODE1;
            3'h2: shift = `SHIFT_CODE2;
            3'h3: shift = `SHIFT_CODE3;
            3'h4: shift = `SHIFT_CODE4;
            3'h5: shift = `SHIFT_CODE5;
            3'h6: shift = `SHIFT_CODE6;
            default: shift = `SHIFT_CODE6;
        endcase
        // divide select doubles the period of every source clock
        presc_mask = ~({`PRESC_W{1'b1}} << (shift + {3'h0, div_sel_q}));
    end

    // prescaler restarts with the timer so the first period is full length
    always_ff @(posedge aclk) begin
        if (!aresetn || !run_q) begin
            presc_q <= `RST_PRESC;
        end else begin
            presc_q <= presc_q + `PRESC_W'(1);
        end
    end

    assign tick = run_q && ((presc_q & presc_mask) == presc_mask);

    // ---------------- count input ----------------
    // phases shorter than one clock period can fall between sampling edges and be lost
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
            pin_prev_q <= 1'b0;
        end else begin
            pin_meta_q <= count_input_pin;
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    assign pin_rise = pin_sync_q && !pin_prev_q;
    assign pin_fall = !pin_sync_q && pin_prev_q;

    // ---------------- counter and outputs ----------------
    assign cnt_inc = cnt_q + 8'h01;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= `RST_COUNT;
            irq_q <= 1'b0;
            div_out_q <= 1'b1;
            pwm_out_q <= 1'b1;
            duty_q <= `RST_COMPARE;
        end else begin
            irq_q <= 1'b0;
            if (!run_q) begin
                cnt_q <= `RST_COUNT;
                div_out_q <= 1'b1;
                pwm_out_q <= 1'b1;
                // tracking while stopped makes the start use the last written duty
                duty_q <= compare_q;
            end else begin
                case (mode_q)
                    timer_pkg::mode_timer: begin
                        if (tick) begin
                            if (cnt_inc == compare_q) begin
                                cnt_q <= `RST_COUNT;
                                irq_q <= 1'b1;
                            end else begin
                                cnt_q <= cnt_inc;
                            end
                        end
                    end
                    timer_pkg::mode_pdo: begin
                        if (tick) begin
                            if (cnt_inc == compare_q) begin
                                cnt_q <= `RST_COUNT;
                                irq_q <= 1'b1;
                                div_out_q <= !div_out_q;
                            end else begin
                                cnt_q <= cnt_inc;
                            end
                        end
                    end
                    timer_pkg::mode_event: begin
                        // external edges drive the count; clock select is not used
                        if (pin_rise) begin
                            cnt_q <= cnt_inc;
                        end else if (pin_fall && cnt_q == compare_q) begin
                            cnt_q <= `RST_COUNT;
                            irq_q <= 1'b1;
                        end
                    end
                    timer_pkg::mode_pwm: begin
                        if (tick) begin
                            cnt_q <= cnt_inc;
                            if (cnt_q == 8'hff) begin
                                pwm_out_q <= 1'b1;
                                irq_q <= 1'b1;
                                duty_q <= compare_q;
                            end else if (cnt_inc == duty_q) begin
                                pwm_out_q <= 1'b0;
                            end
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    assign timer_match_irq = irq_q;
    assign divider_output_n = div_out_q;
    assign pulse_width_output_n = pwm_out_q;

    // ---------------- checks ----------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_stop_clears_run: assert property (stop_entry |=> !run_q)
        else $error("stop entry did not clear run bit");

    a_stopped_div_high: assert property (!run_q ##1 !run_q |-> divider_output_n)
        else $error("divider output low while stopped");

    a_stopped_pwm_high: assert property (!run_q ##1 !run_q |-> pulse_width_output_n)
        else $error("pwm output low while stopped");

    a_stopped_count_zero: assert property (!run_q |=> cnt_q == 8'h00)
        else $error("counter not cleared while stopped");

    a_timer_match_clear: assert property (
        run_q && mode_q == timer_pkg::mode_timer && tick && cnt_inc == compare_q
        |=> cnt_q == 8'h00 && timer_match_irq)
        else $error("timer match did not clear and interrupt");

    a_pdo_match_toggle: assert property (
        run_q && mode_q == timer_pkg::mode_pdo && tick && cnt_inc == compare_q
        |=> divider_output_n != $past(divider_output_n) && timer_match_irq)
        else $error("divider output did not toggle on match");

    a_event_rise_count: assert property (
        run_q && mode_q == timer_pkg::mode_event && pin_rise
        |=> cnt_q == $past(cnt_inc) && !timer_match_irq)
        else $error("event rising edge not counted");

    a_event_fall_match: assert property (
        run_q && mode_q == timer_pkg::mode_event && pin_fall && cnt_q == compare_q
        |=> cnt_q == 8'h00 && timer_match_irq)
        else $error("event match not taken on falling edge");

    a_pwm_duty_low: assert property (
        run_q && mode_q == timer_pkg::mode_pwm && tick && cnt_q != 8'hff && cnt_inc == duty_q
        |=> !pulse_width_output_n)
        else $error("pwm output not low at duty match");

    a_pwm_period_end: assert property (
        run_q && mode_q == timer_pkg::mode_pwm && tick && cnt_q == 8'hff
        |=> pulse_width_output_n && timer_match_irq && duty_q == $past(compare_q))
        else $error("pwm overflow did not reload duty");

    a_pwm_start_load: assert property (
        !run_q ##1 run_q |-> duty_q == $past(compare_q))
        else $error("start did not load written duty");

    a_bus_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped before taken");

    c_timer_match: cover property (mode_q == timer_pkg::mode_timer && timer_match_irq);
    c_pdo_toggle: cover property (mode_q == timer_pkg::mode_pdo && $fell(divider_output_n));
    c_event_match: cover property (mode_q == timer_pkg::mode_event && timer_match_irq);
    c_pwm_period: cover property ($fell(pulse_width_output_n) ##[1:600] timer_match_irq);

endmodule

//--- verif/pulse_source_load.sv
// external count pulse source and pwm output load for the 8-bit timer bench
`timescale 1ns/1ps
module pulse_source_load #(
    parameter int PHASE = 8
) (
    input wire logic aclk,
    input wire logic timer_match_irq,
    input wire logic pulse_width_output_n,
    output logic count_input_pin,
    output logic [9:0] low_last
);
    logic [9:0] low_cnt;
    initial begin
        count_input_pin = 1'b0;
    end
    // callers enter just after a clock edge; each phase lasts PHASE periods
    task automatic rise();
        count_input_pin <= 1'b1;
        repeat (PHASE) @(posedge aclk);
    endtask
    task automatic fall();
        count_input_pin <= 1'b0;
        repeat (PHASE) @(posedge aclk);
    endtask
    task automatic pulse();
        rise();
        fall();
    endtask
    // the load times the low part of each pwm period, closed by the irq
    always @(posedge aclk) begin
        if (timer_match_irq === 1'b1) begin
            low_last <= low_cnt;
            low_cnt <= 10'h000;
        end else if (pulse_width_output_n === 1'b0) begin
            low_cnt <= low_cnt + 10'h001;
        end
    end
endmodule

//--- verif/tb_eight_bit_multimode_timer.sv
// testbench of the 8-bit timer: register port, all four modes, stop handling
`timescale 1ns/1ps
module tb_eight_bit_multimode_timer;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, stop_entry, d1;
    logic count_input_pin, timer_match_irq, divider_output_n, pulse_width_output_n;
    logic [31:0] awaddr, wdata, araddr, rdata, rd_q;
    logic [3:0] wstrb;
    logic [2:0] awprot, arprot;
    logic [1:0] bresp, rresp, resp_q;
    logic [9:0] low_last, l1, l2;
    int err_count, total_checks, cyc, last, gap, irq_cnt, i0;

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    eight_bit_multimode_timer i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awprot(awprot), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(arprot), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .count_input_pin(count_input_pin), .stop_entry(stop_entry),
        .timer_match_irq(timer_match_irq), .divider_output_n(divider_output_n),
        .pulse_width_output_n(pulse_width_output_n));

    pulse_source_load i_src (.aclk(aclk), .timer_match_irq(timer_match_irq),
        .pulse_width_output_n(pulse_width_output_n), .count_input_pin(count_input_pin),
        .low_last(low_last));

    // the whole run needs a few thousand cycles; this ceiling cuts a hang short
    always @(posedge aclk) begin
        cyc++;
        if (timer_match_irq === 1'b1) begin
            gap = cyc - last;
            last = cyc;
            irq_cnt++;
        end
        if (cyc == 10000) begin
            err_count++;
            test_done();
        end
    end

    function automatic logic [31:0] ctl(input logic [1:0] m, input logic [2:0] c, input logic r);
        return {26'h0, r, m, c};
    endfunction

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do @(posedge aclk); while (awready !== 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        // one cycle of back-pressure so the write response has to stand
        @(posedge aclk);
        bready <= 1'b1;
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        resp_q = bresp;
    endtask

    task automatic rd(input logic [31:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rd_q = rdata;
        resp_q = rresp;
    endtask

    // returns one edge after the irq so that every monitor has updated
    task automatic wirq();
        int i;
        i = irq_cnt;
        while (irq_cnt == i) @(posedge aclk);
        @(posedge aclk);
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, arvalid, stop_entry} = 4'h0;
        // reads are accepted at once; writes hold off bready for one cycle
        bready = 1'b0;
        rready = 1'b1;
        {awaddr, wdata, araddr} = {32'h0, 32'h0, 32'h0};
        {awprot, arprot} = 6'h00;
        wstrb = 4'hf;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(32'h0);
        chk("control", 32'h0, rd_q);
        rd(32'h4);
        chk("compare", 32'hff, rd_q);
        rd(32'h8);
        chk("status", 32'h300, rd_q);
        rd(32'h10);
        chk("rresp", 32'h2, resp_q);
        chk("rdata", 32'h0, rd_q);
        wr(32'h10, 32'h5);
        chk("bresp", 32'h2, resp_q);
        wr(32'h0, 32'hc0);
        rd(32'h0);
        chk("control", 32'h0, rd_q);
        wstrb <= 4'he;
        wr(32'h4, 32'h11);
        wstrb <= 4'hf;
        rd(32'h4);
        chk("masked write", 32'hff, rd_q);
        for (int s = 0; s < 2; s++) begin
            wr(32'hc, s);
            wr(32'h4, 32'h4);
            wr(32'h0, ctl(2'h0, 3'h3, 1'b0));
            wr(32'h0, ctl(2'h0, 3'h3, 1'b1));
            wirq();
            wirq();
            chk("timer period", 32 << s, gap);
            wr(32'h0, ctl(2'h0, 3'h3, 1'b0));
            rd(32'h8);
            chk("status", 32'h300, rd_q);
        end
        wr(32'hc, 32'h0);
        wr(32'h4, 32'h3);
        wr(32'h0, ctl(2'h2, 3'h2, 1'b0));
        wr(32'h0, ctl(2'h2, 3'h2, 1'b1));
        wirq();
        d1 = divider_output_n;
        wirq();
        chk("divider gap", 32'h60, gap);
        chk("divider level", {~d1}, {divider_output_n});
        if (divider_output_n === 1'b1) wirq();
        wr(32'h0, ctl(2'h2, 3'h2, 1'b0));
        rd(32'h8);
        chk("status", 32'h300, rd_q);
        // duty written before start must govern the first period
        wr(32'h4, 32'h40);
        wr(32'h0, ctl(2'h3, 3'h5, 1'b0));
        wr(32'h0, ctl(2'h3, 3'h5, 1'b1));
        wirq();
        l1 = low_last;
        wr(32'h4, 32'h20);
        wirq();
        l2 = low_last;
        chk("pwm low", 32'h180, l1);
        chk("pwm low", l1, l2);
        chk("pwm period", 32'h200, gap);
        wirq();
        chk("pwm low diff", 32'h40, low_last - l2);
        wr(32'h0, ctl(2'h3, 3'h5, 1'b0));
        rd(32'h8);
        chk("status", 32'h300, rd_q);
        wr(32'h4, 32'h3);
        wr(32'h0, ctl(2'h1, 3'h7, 1'b0));
        wr(32'h0, ctl(2'h1, 3'h7, 1'b1));
        i0 = irq_cnt;
        i_src.pulse();
        i_src.pulse();
        rd(32'h8);
        chk("event count", 32'h2, rd_q[7:0]);
        i_src.rise();
        rd(32'h8);
        chk("event count", 32'h3, rd_q[7:0]);
        chk("irq count", i0, irq_cnt);
        i_src.fall();
        rd(32'h8);
        chk("event count", 32'h0, rd_q[7:0]);
        chk("irq count", i0 + 1, irq_cnt);
        i_src.pulse();
        rd(32'h8);
        chk("event count", 32'h1, rd_q[7:0]);
        stop_entry <= 1'b1;
        @(posedge aclk);
        stop_entry <= 1'b0;
        rd(32'h0);
        chk("control", ctl(2'h1, 3'h7, 1'b0), rd_q);
        rd(32'h8);
        chk("event count", 32'h0, rd_q[7:0]);
        test_done();
    end
endmodule
